/* File: rtl/rfae_pkg.sv */
package rfae_pkg;

	localparam int DATA_W   = 8;
	localparam int ADDR_W   = 7;
	localparam int IMM_W    = 11;
	localparam int PC_W     = 13;
	localparam int LATCH_W  = 5;
	localparam int RF_DEPTH = 128;

	// page bits of the high latch that feed the upper program counter
	localparam int LATCH_PAGE_HI = 4;
	localparam int LATCH_PAGE_LO = 3;

	localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST    = 13'h0000;
	localparam logic              ZERO_RST  = 1'b0;
	localparam logic [DATA_W-1:0] ONE_VAL   = 8'h01;
	localparam logic [DATA_W-1:0] NULL_VAL  = 8'h00;
	localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;

	// destination select encoding
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_REG = 1'b1;

	typedef enum logic [2:0] {
		OP_NONE                        = 3'h0,
		OP_INCREMENT_SKIP_IF_NULL      = 3'h1,
		OP_UNCONDITIONAL_JUMP          = 3'h2,
		OP_OR_LITERAL_INTO_ACCUMULATOR = 3'h3,
		OP_INCREMENT_REGISTER          = 3'h4,
		OP_OR_ACCUMULATOR_AND_REGISTER = 3'h5,
		OP_MOVE_REGISTER               = 3'h6
	} rfae_op_t;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_FILL = 2'b10
	} rfae_state_t;

endpackage : rfae_pkg

/* File: rtl/rfae_alu.sv */
`timescale 1ns/100ps
module rfae_alu
	import rfae_pkg::*;
(
	input  rfae_pkg::rfae_op_t          op,
	input  wire logic [rfae_pkg::DATA_W-1:0] acc,
	input  wire logic [rfae_pkg::DATA_W-1:0] fval,
	input  wire logic [rfae_pkg::DATA_W-1:0] lit,
	output logic      [rfae_pkg::DATA_W-1:0] result,
	output logic                        upd_zero,
	output logic                        uses_dest
);

	always_comb begin
		result    = NULL_VAL;
		upd_zero  = 1'b0;
		uses_dest = 1'b0;
		case (op)
			OP_INCREMENT_SKIP_IF_NULL: begin
				// flags untouched here, the zero result only drives the skip
				result    = fval + ONE_VAL;
				uses_dest = 1'b1;
			end
			OP_OR_LITERAL_INTO_ACCUMULATOR: begin
				result   = acc | lit;
				upd_zero = 1'b1;
			end
			OP_INCREMENT_REGISTER: begin
				// 8-bit sum, so 8'hFF wraps to zero
				result    = fval + ONE_VAL;
				upd_zero  = 1'b1;
				uses_dest = 1'b1;
			end
			OP_OR_ACCUMULATOR_AND_REGISTER: begin
				result    = acc | fval;
				upd_zero  = 1'b1;
				uses_dest = 1'b1;
			end
			OP_MOVE_REGISTER: begin
				result    = fval;
				upd_zero  = 1'b1;
				uses_dest = 1'b1;
			end
			default: begin
				result    = NULL_VAL;
				upd_zero  = 1'b0;
				uses_dest = 1'b0;
			end
		endcase
	end

endmodule : rfae_alu

/* File: rtl/rfae_regfile.sv */
`timescale 1ns/100ps
module rfae_regfile
	import rfae_pkg::*;
(
	input  wire logic                        clk_sys,
	input  wire logic                        ce,
	input  wire logic                        wr_en,
	input  wire logic [rfae_pkg::ADDR_W-1:0] wr_addr,
	input  wire logic [rfae_pkg::DATA_W-1:0] wr_data,
	input  wire logic [rfae_pkg::ADDR_W-1:0] rd_addr_a,
	output logic      [rfae_pkg::DATA_W-1:0] rd_data_a,
	input  wire logic [rfae_pkg::ADDR_W-1:0] rd_addr_b,
	output logic      [rfae_pkg::DATA_W-1:0] rd_data_b
);

	// no reset: contents are loaded by the user before use
	logic [DATA_W-1:0] mem [RF_DEPTH];

	always_ff @(posedge clk_sys) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_comb begin
		rd_data_a = mem[rd_addr_a];
		rd_data_b = mem[rd_addr_b];
	end

endmodule : rfae_regfile

/* File: rtl/rfae_core.sv */
`timescale 1ns/100ps
module rfae_core
	import rfae_pkg::*;
(
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire logic                         ce,
	input  wire logic                         instr_valid,
	input  rfae_pkg::rfae_op_t                instr_op,
	input  wire logic [rfae_pkg::ADDR_W-1:0]  instr_addr,
	input  wire logic                         instr_dest,
	input  wire logic [rfae_pkg::IMM_W-1:0]   instr_imm,
	input  wire logic [rfae_pkg::LATCH_W-1:0] program_counter_high_latch,
	input  wire logic                         load_valid,
	input  wire logic [rfae_pkg::ADDR_W-1:0]  load_addr,
	input  wire logic [rfae_pkg::DATA_W-1:0]  load_data,
	input  wire logic [rfae_pkg::ADDR_W-1:0]  peek_addr,
	output logic                              ready_ff,
	output logic      [rfae_pkg::PC_W-1:0]    pc_ff,
	output logic      [rfae_pkg::DATA_W-1:0]  accum_ff,
	output logic                              zero_ff,
	output logic                              skip_armed_ff,
	output logic                              retire_ff,
	output logic                              discard_ff,
	output logic      [rfae_pkg::DATA_W-1:0]  peek_data_ff
);

	////////////////////////////////////////////////////////////////////////
	// datapath

	rfae_state_t       state_ff;
	rfae_state_t       nxt_state;
	logic              nxt_ready;
	logic [PC_W-1:0]   nxt_pc;
	logic [DATA_W-1:0] nxt_accum;
	logic              nxt_zero;
	logic              nxt_skip_armed;
	logic              nxt_retire;
	logic              nxt_discard;
	logic [DATA_W-1:0] nxt_peek;

	logic              take;
	logic              exec;
	logic [DATA_W-1:0] fval;
	logic [DATA_W-1:0] peek_val;
	logic [DATA_W-1:0] alu_result;
	logic              alu_upd_zero;
	logic              alu_uses_dest;
	logic              rf_wr_en;
	logic [ADDR_W-1:0] rf_wr_addr;
	logic [DATA_W-1:0] rf_wr_data;
	logic              res_null;

	// requests are taken only in the run state; the fill state is the jump's bubble
	assign take     = ce && instr_valid && (state_ff == ST_RUN);
	// a taken instruction while a skip is armed is swallowed
	assign exec     = take && !skip_armed_ff;
	assign res_null = (alu_result == NULL_VAL);

	rfae_alu u_alu (
		.op        (instr_op),
		.acc       (accum_ff),
		.fval      (fval),
		.lit       (instr_imm[DATA_W-1:0]),
		.result    (alu_result),
		.upd_zero  (alu_upd_zero),
		.uses_dest (alu_uses_dest)
	);

	rfae_regfile u_rf (
		.clk_sys   (clk_sys),
		.ce        (ce),
		.wr_en     (rf_wr_en),
		.wr_addr   (rf_wr_addr),
		.wr_data   (rf_wr_data),
		.rd_addr_a (instr_addr),
		.rd_data_a (fval),
		.rd_addr_b (peek_addr),
		.rd_data_b (peek_val)
	);

	////////////////////////////////////////////////////////////////////////
	// register-file write port

	// instruction write-back beats the user load port in the same cycle
	always_comb begin
		rf_wr_en   = 1'b0;
		rf_wr_addr = load_addr;
		rf_wr_data = load_data;
		if (exec && alu_uses_dest && (instr_dest == DEST_REG)) begin
			rf_wr_en   = 1'b1;
			rf_wr_addr = instr_addr;
			rf_wr_data = alu_result;
		end else if (load_valid) begin
			rf_wr_en   = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing and architectural state

	always_comb begin
		nxt_state      = state_ff;
		nxt_pc         = pc_ff;
		nxt_accum      = accum_ff;
		nxt_zero       = zero_ff;
		nxt_skip_armed = skip_armed_ff;
		nxt_retire     = 1'b0;
		nxt_discard    = 1'b0;
		nxt_peek       = peek_val;
		case (state_ff)
			ST_RUN: begin
				if (take && skip_armed_ff) begin
					// discarded slot still advances the pc like a no-op
					nxt_skip_armed = 1'b0;
					nxt_discard    = 1'b1;
					nxt_pc         = pc_ff + PC_STEP;
				end else if (exec) begin
					nxt_retire = 1'b1;
					nxt_pc     = pc_ff + PC_STEP;
					if (instr_op == OP_UNCONDITIONAL_JUMP) begin
						nxt_pc    = {program_counter_high_latch[LATCH_PAGE_HI:LATCH_PAGE_LO],
							instr_imm};
						nxt_state = ST_FILL;
					end else if (instr_op == OP_OR_LITERAL_INTO_ACCUMULATOR) begin
						nxt_accum = alu_result;
					end else if (alu_uses_dest && (instr_dest == DEST_ACC)) begin
						nxt_accum = alu_result;
					end
					if (alu_upd_zero) begin
						nxt_zero = res_null;
					end
					// only the skip form arms; plain increment never does
					if ((instr_op == OP_INCREMENT_SKIP_IF_NULL) && res_null) begin
						nxt_skip_armed = 1'b1;
					end
				end
			end
			ST_FILL: begin
				// second cycle of the jump: nothing is taken
				if (ce) begin
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
		nxt_ready = (nxt_state == ST_RUN);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff      <= ST_RUN;
			ready_ff      <= 1'b1;
			pc_ff         <= PC_RST;
			accum_ff      <= ACC_RST;
			zero_ff       <= ZERO_RST;
			skip_armed_ff <= 1'b0;
			retire_ff     <= 1'b0;
			discard_ff    <= 1'b0;
			peek_data_ff  <= NULL_VAL;
		end else if (ce) begin
			state_ff      <= nxt_state;
			ready_ff      <= nxt_ready;
			pc_ff         <= nxt_pc;
			accum_ff      <= nxt_accum;
			zero_ff       <= nxt_zero;
			skip_armed_ff <= nxt_skip_armed;
			retire_ff     <= nxt_retire;
			discard_ff    <= nxt_discard;
			peek_data_ff  <= nxt_peek;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	inc_skip_flags_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_INCREMENT_SKIP_IF_NULL) |=> $stable(zero_ff))
		else $error("increment-skip changed the zero flag");

	skip_arms_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_INCREMENT_SKIP_IF_NULL) |=>
			(skip_armed_ff == ($past(fval) == 8'hFF)))
		else $error("skip not armed exactly on a zero increment");

	skip_discard_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		take && skip_armed_ff |=>
			discard_ff && !retire_ff && !skip_armed_ff && $stable(accum_ff) && $stable(zero_ff))
		else $error("armed skip did not discard the next instruction");

	dest_acc_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && alu_uses_dest && (instr_dest == DEST_ACC) |=>
			(accum_ff == $past(alu_result)))
		else $error("result missing from accumulator");

	dest_reg_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && alu_uses_dest && (instr_dest == DEST_REG) |=> $stable(accum_ff))
		else $error("register destination altered the accumulator");

	jump_target_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_UNCONDITIONAL_JUMP) |=>
			(pc_ff == {$past(program_counter_high_latch[4:3]), $past(instr_imm)}))
		else $error("jump target wrongly composed");

	jump_two_cycle_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_UNCONDITIONAL_JUMP) && ce ##1 ce |->
			!ready_ff && $stable(zero_ff) ##1 ready_ff)
		else $error("jump did not take two cycles");

	or_literal_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_OR_LITERAL_INTO_ACCUMULATOR) |=>
			(accum_ff == ($past(accum_ff) | $past(instr_imm[7:0]))) &&
			(zero_ff == (accum_ff == 8'h00)))
		else $error("or-literal result or zero flag wrong");

	inc_wrap_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_INCREMENT_REGISTER) && (instr_dest == DEST_ACC) &&
			(fval == 8'hFF) |=> (accum_ff == 8'h00) && zero_ff && !skip_armed_ff)
		else $error("increment of 255 did not wrap with zero set");

	zero_flag_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && alu_upd_zero |=> (zero_ff == ($past(alu_result) == 8'h00)))
		else $error("zero flag does not follow result");

	move_test_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_MOVE_REGISTER) && (instr_dest == DEST_ACC) |=>
			(accum_ff == $past(fval)) && (zero_ff == ($past(fval) == 8'h00)))
		else $error("move result or zero flag wrong");

	or_reg_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_OR_ACCUMULATOR_AND_REGISTER) && (instr_dest == DEST_ACC) |=>
			(accum_ff == ($past(accum_ff) | $past(fval))))
		else $error("or-register result wrong");

	rf_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && alu_uses_dest && (instr_dest == DEST_REG) |->
			rf_wr_en && (rf_wr_addr == instr_addr) && (rf_wr_data == alu_result))
		else $error("register destination not written back");

	lit_no_write_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_OR_LITERAL_INTO_ACCUMULATOR) |-> (rf_wr_en == load_valid))
		else $error("or-literal wrote the register file");

	inc_no_skip_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_INCREMENT_REGISTER) |=> retire_ff && !skip_armed_ff)
		else $error("plain increment armed a skip");

	skip_pc_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		take && skip_armed_ff |=> ready_ff && (pc_ff == $past(pc_ff) + PC_STEP))
		else $error("discarded slot did not advance like a no-op");

	skip_inc_value_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_INCREMENT_SKIP_IF_NULL) && (instr_dest == DEST_ACC) |=>
			(accum_ff == $past(fval) + ONE_VAL))
		else $error("increment-skip sum missing from accumulator");

	move_keep_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_MOVE_REGISTER) && (instr_dest == DEST_REG) |=>
			$stable(accum_ff) && (zero_ff == ($past(fval) == NULL_VAL)))
		else $error("move onto a register changed the accumulator or missed zero");

	jump_flags_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		exec && (instr_op == OP_UNCONDITIONAL_JUMP) |=>
			retire_ff && $stable(accum_ff) && $stable(zero_ff) && !skip_armed_ff)
		else $error("jump changed the accumulator or flags");

	bubble_refuse_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		!ready_ff && ce && instr_valid |=> !retire_ff && !discard_ff && $stable(accum_ff))
		else $error("instruction taken during the jump bubble");

endmodule : rfae_core

/* File: test/rfae_core_tb_top.sv */
`timescale 1ns/100ps
module rfae_core_tb_top;
	import rfae_pkg::*;

	typedef struct {
		rfae_op_t   op;
		logic [6:0] a;
		logic       d;
		logic [10:0] imm;
		logic [7:0] acc0;
		logic [7:0] f;
	} rfae_row_t;

	logic        clk_sys;
	logic        rst;
	logic        ce;
	logic        instr_valid;
	rfae_op_t    instr_op;
	logic [6:0]  instr_addr;
	logic        instr_dest;
	logic [10:0] instr_imm;
	logic [4:0]  latch;
	logic        load_valid;
	logic [6:0]  load_addr;
	logic [7:0]  load_data;
	logic [6:0]  peek_addr;
	logic        ready_ff;
	logic [12:0] pc_ff;
	logic [7:0]  accum_ff;
	logic        zero_ff;
	logic        skip_armed_ff;
	logic        retire_ff;
	logic        discard_ff;
	logic [7:0]  peek_data_ff;
	int          n_fail;
	int          n_tests;
	logic [12:0] epc;
	logic [7:0]  res;
	logic        wr;
	logic        z0;
	rfae_row_t   rows [9];

	rfae_core dut_u (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_addr(instr_addr), .instr_dest(instr_dest),
		.instr_imm(instr_imm), .program_counter_high_latch(latch),
		.load_valid(load_valid), .load_addr(load_addr), .load_data(load_data),
		.peek_addr(peek_addr), .ready_ff(ready_ff), .pc_ff(pc_ff), .accum_ff(accum_ff),
		.zero_ff(zero_ff), .skip_armed_ff(skip_armed_ff), .retire_ff(retire_ff),
		.discard_ff(discard_ff), .peek_data_ff(peek_data_ff)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task automatic ld(logic [6:0] a, logic [7:0] v);
		load_valid = 1'b1;
		load_addr  = a;
		load_data  = v;
		@(negedge clk_sys);
		load_valid = 1'b0;
	endtask : ld

	// returns at the negedge after the taking edge, where retire/discard stand
	// hold keeps valid up when another request follows at once
	task automatic issue(rfae_op_t op, logic [6:0] a, logic d, logic [10:0] imm,
		logic hold = 1'b0);
		instr_valid = 1'b1;
		instr_op    = op;
		instr_addr  = a;
		instr_dest  = d;
		instr_imm   = imm;
		@(negedge clk_sys);
		if (!hold) begin
			instr_valid = 1'b0;
		end
		epc         = epc + 13'h0001;
	endtask : issue

	task automatic peek(logic [6:0] a);
		peek_addr = a;
		@(negedge clk_sys);
	endtask : peek

	task automatic do_reset(int n);
		rst = 1'b1;
		repeat (n) @(negedge clk_sys);
		rst = 1'b0;
		epc = 13'h0000;
		chk("reset", {ready_ff, skip_armed_ff, zero_ff, retire_ff, discard_ff, accum_ff}, 13'h1000);
		chk("reset_pc", pc_ff, 13'h0000);
		chk("reset_peek", peek_data_ff, 8'h00);
	endtask : do_reset

	function automatic logic [7:0] calc(rfae_row_t r);
		case (r.op)
			OP_OR_LITERAL_INTO_ACCUMULATOR: return r.acc0 | r.imm[7:0];
			OP_OR_ACCUMULATOR_AND_REGISTER: return r.acc0 | r.f;
			OP_MOVE_REGISTER:               return r.f;
			default:                        return r.f + 8'h01;
		endcase
	endfunction : calc

	initial begin
		repeat (3000) @(posedge clk_sys);
		n_fail++;
		end_of_test();
	end

	initial begin
		n_fail = 0; n_tests = 0; rst = 1'b1; ce = 1'b1; instr_valid = 1'b0;
		instr_op = OP_NONE; instr_addr = 7'h00; instr_dest = 1'b0; instr_imm = 11'h000;
		latch = 5'h00; load_valid = 1'b0; load_addr = 7'h00; load_data = 8'h00;
		peek_addr = 7'h00; epc = 13'h0000;
		rows = '{
			'{OP_INCREMENT_REGISTER, 7'h05, 1'b0, 11'h000, 8'h33, 8'hFF},
			'{OP_INCREMENT_REGISTER, 7'h06, 1'b1, 11'h000, 8'h00, 8'h7F},
			'{OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h07, 1'b1, 11'h70A, 8'h50, 8'h11},
			'{OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h08, 1'b0, 11'h000, 8'h00, 8'h22},
			'{OP_OR_ACCUMULATOR_AND_REGISTER, 7'h7F, 1'b1, 11'h000, 8'h0F, 8'hF0},
			'{OP_OR_ACCUMULATOR_AND_REGISTER, 7'h00, 1'b0, 11'h000, 8'h00, 8'h00},
			'{OP_MOVE_REGISTER, 7'h09, 1'b1, 11'h000, 8'h44, 8'h00},
			'{OP_MOVE_REGISTER, 7'h0A, 1'b0, 11'h000, 8'h00, 8'hC3},
			'{OP_INCREMENT_SKIP_IF_NULL, 7'h0B, 1'b1, 11'h000, 8'h00, 8'h41}
		};
		do_reset(8);
		foreach (rows[i]) begin
			ld(7'h7E, rows[i].acc0);
			issue(OP_MOVE_REGISTER, 7'h7E, DEST_ACC, 11'h000);
			ld(rows[i].a, rows[i].f);
			issue(rows[i].op, rows[i].a, rows[i].d, rows[i].imm);
			res = calc(rows[i]);
			wr  = rows[i].d && rows[i].op != OP_OR_LITERAL_INTO_ACCUMULATOR;
			chk("retire", retire_ff, 1'b1);
			chk("accum", accum_ff, wr ? rows[i].acc0 : res);
			chk("zero", zero_ff, (rows[i].op == OP_INCREMENT_SKIP_IF_NULL) ?
				(rows[i].acc0 == 8'h00) : (res == 8'h00));
			chk("skip", skip_armed_ff, 1'b0);
			chk("pc", pc_ff, epc);
			peek(rows[i].a);
			chk("reg", peek_data_ff, wr ? res : rows[i].f);
		end
		////////////////////////////////////////////////////////////////
		// zero result: the following instruction is swallowed
		ld(7'h14, 8'hFF);
		z0 = zero_ff;
		issue(OP_INCREMENT_SKIP_IF_NULL, 7'h14, DEST_REG, 11'h000, 1'b1);
		chk("skip", {skip_armed_ff, zero_ff}, {1'b1, z0});
		issue(OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, DEST_ACC, 11'h0FF);
		chk("discard", {discard_ff, retire_ff, skip_armed_ff}, 3'h4);
		chk("accum", accum_ff, 8'h00);
		chk("pc", pc_ff, epc);
		peek(7'h14);
		chk("reg", peek_data_ff, 8'h00);
		// a swallowed jump must not move the page or stall
		issue(OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, DEST_ACC, 11'h05A);
		ld(7'h15, 8'hFF);
		issue(OP_INCREMENT_SKIP_IF_NULL, 7'h15, DEST_ACC, 11'h000, 1'b1);
		chk("accum", {skip_armed_ff, zero_ff, accum_ff}, 10'h200);
		latch = 5'h17;
		issue(OP_UNCONDITIONAL_JUMP, 7'h00, DEST_ACC, 11'h7FF, 1'b1);
		chk("pc", {ready_ff, discard_ff, pc_ff}, {2'b11, epc});
		////////////////////////////////////////////////////////////////
		z0 = zero_ff;
		issue(OP_UNCONDITIONAL_JUMP, 7'h00, DEST_ACC, 11'h7FF, 1'b1);
		chk("jump_pc", pc_ff, 13'h17FF);
		chk("jump", {ready_ff, retire_ff, zero_ff}, {2'b01, z0});
		// offered during the bubble: ignored, not queued
		instr_valid = 1'b1;
		instr_op    = OP_OR_LITERAL_INTO_ACCUMULATOR;
		instr_imm   = 11'h0FF;
		@(negedge clk_sys);
		instr_valid = 1'b0;
		chk("bubble", {ready_ff, retire_ff, accum_ff}, 10'h200);
		chk("bubble_pc", pc_ff, 13'h17FF);
		@(negedge clk_sys);
		latch = 5'h08;
		issue(OP_UNCONDITIONAL_JUMP, 7'h00, DEST_ACC, 11'h000);
		chk("jump_pc", pc_ff, 13'h0800);
		@(negedge clk_sys);
		epc = 13'h0800;
		////////////////////////////////////////////////////////////////
		ce = 1'b0;
		issue(OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, DEST_ACC, 11'h0FF, 1'b1);
		chk("frozen", {retire_ff, accum_ff}, 9'h000);
		chk("frozen_pc", pc_ff, 13'h0800);
		ce = 1'b1;
		issue(OP_OR_LITERAL_INTO_ACCUMULATOR, 7'h00, DEST_ACC, 11'h081);
		chk("orlit", {zero_ff, accum_ff}, 9'h081);
		// load and write-back to one address in one cycle: write-back wins
		ld(7'h21, 8'h10);
		peek(7'h21);
		load_valid = 1'b1;
		load_addr  = 7'h21;
		load_data  = 8'h99;
		issue(OP_INCREMENT_REGISTER, 7'h21, DEST_REG, 11'h000);
		load_valid = 1'b0;
		peek(7'h21);
		chk("clash", {zero_ff, peek_data_ff}, 9'h011);
		// reset must act while frozen
		ce = 1'b0;
		do_reset(2);
		end_of_test();
	end
endmodule : rfae_core_tb_top
